// file: rtl/coproc_exc_proc.sv
// Processor end: issues coprocessor dialog and handles take-exception primitives
`timescale 1ns/1ps
`include "coproc_exc_regs.svh"

//==================================================================
// Summary of operation
// RULE_01: Midinstruction word upper byte 0,flag,011101, vector low
// RULE_02: Postinstruction word upper byte 0,flag,011110, vector low
// RULE_03: Write acknowledge mask before exception processing
// RULE_04: Exception vector comes from primitive field
// RULE_05: Pre frame four words, pc is opcode address
// RULE_06: Unmodified pre frame return restarts instruction
// RULE_07: Mid frame ten words, pc, scan, ea
// RULE_08: Mid frame ea undefined without evaluation
// RULE_09: Unmodified mid return rereads response register
// RULE_10: Post frame six words, scan and pc
// RULE_11: Unmodified post return fetches at scan pointer
// RULE_12: Coprocessor uses post at completion or abort
// RULE_13: Accept primitives in both instruction categories
// RULE_14: Coprocessor avoids pre after visible changes
// RULE_15: Pre answers unknown command or early exception
// RULE_16: Concurrent exception deferred to next instruction start
// RULE_17: Come-again clear releases processor early
// RULE_18: Coprocessor records address via flag before release
// RULE_19: Coprocessor uses mid during instruction dialog
// RULE_20: Pre code is distinct parameter, same layout
module coproc_exc_proc
   import coproc_exc_pkg::*;
#(
   parameter logic [7:0] PRE_CODE = `PRIM_CODE_PRE
) (
   input  wire logic                        clk,
   input  wire logic                        reset_n,
   coproc_interface_register_if.proc        bus,
   input  wire logic                        start,
   input  wire logic                        conditional,
   input  wire logic [15:0]                 op_word,
   input  wire logic [31:0]                 opcode_addr,
   input  wire logic [31:0]                 scan_ptr,
   input  wire logic                        ea_valid,
   input  wire logic [31:0]                 ea,
   input  wire logic                        return_from_exception_op,
   input  wire logic                        frame_modified,
   output logic                             busy,
   output logic                             exc_frame,
   output coproc_exc_pkg::frame_kind_e      frame_kind,
   output logic [3:0]                       frame_words,
   output logic [7:0]                       exc_vector,
   output logic [31:0]                      frame_pc,
   output logic [31:0]                      frame_scan,
   output logic [31:0]                      frame_ea,
   output logic                             released,
   output logic                             restart,
   output logic                             fetch_valid,
   output logic [31:0]                      fetch_addr
);
   import coproc_exc_pkg::*;

   typedef enum logic [2:0] {
      P_IDLE,
      P_CMD,
      P_RESP,
      P_ACK,
      P_FRAME
   } proc_state_e;

   // Classify a primitive word, the address flag is ignored in the match
   function automatic frame_kind_e classify(input logic [15:0] w, input logic [7:0] pre_code);
      logic [7:0] code;
      code = w[15:8] & `PRIM_CODE_MASK;
      if (code == pre_code)
         classify = FRAME_PRE;
      else if (code == `PRIM_CODE_MID)
         classify = FRAME_MID;
      else if (code == `PRIM_CODE_POST)
         classify = FRAME_POST;
      else
         classify = FRAME_NONE;
   endfunction : classify

   proc_state_e  state;
   proc_state_e  next_state;
   logic         next_req;
   logic         next_write;
   logic [2:0]   next_sel;
   logic [15:0]  next_wdata;
   logic [15:0]  cmd_word;
   logic [15:0]  next_cmd_word;
   logic         is_cond;
   logic         next_is_cond;
   logic [31:0]  cur_opcode;
   logic [31:0]  next_cur_opcode;
   logic [31:0]  cur_scan;
   logic [31:0]  next_cur_scan;
   logic [31:0]  cur_ea;
   logic [31:0]  next_cur_ea;
   logic         next_busy;
   logic         next_exc_frame;
   frame_kind_e  next_frame_kind;
   logic [3:0]   next_frame_words;
   logic [7:0]   next_exc_vector;
   logic [31:0]  next_frame_pc;
   logic [31:0]  next_frame_scan;
   logic [31:0]  next_frame_ea;
   logic         next_released;
   logic         next_restart;
   logic         next_fetch_valid;
   logic [31:0]  next_fetch_addr;
   frame_kind_e  resp_kind;

   assign resp_kind = classify(bus.rdata, PRE_CODE); // RULE_01 RULE_02 RULE_20

   //==================================================================
   // Dialog sequencing
   always_comb begin
      next_state       = state;
      next_req         = bus.req;
      next_write       = bus.write;
      next_sel         = bus.sel;
      next_wdata       = bus.wdata;
      next_cmd_word    = cmd_word;
      next_is_cond     = is_cond;
      next_cur_opcode  = cur_opcode;
      next_cur_scan    = cur_scan;
      next_cur_ea      = cur_ea;
      next_busy        = busy;
      next_exc_frame   = exc_frame;
      next_frame_kind  = frame_kind;
      next_frame_words = frame_words;
      next_exc_vector  = exc_vector;
      next_frame_pc    = frame_pc;
      next_frame_scan  = frame_scan;
      next_frame_ea    = frame_ea;
      next_released    = 1'b0;
      next_restart     = 1'b0;
      next_fetch_valid = 1'b0;
      next_fetch_addr  = fetch_addr;
      case (state)
         P_IDLE: begin
            if (start) begin
               next_cmd_word   = op_word;
               next_is_cond    = conditional;
               next_cur_opcode = opcode_addr;
               next_cur_scan   = scan_ptr;
               // Without an evaluated address the field is left at zero, any value is legal there
               next_cur_ea     = ea_valid ? ea : 32'h0000_0000; // RULE_08
               next_busy       = 1'b1;
               next_req        = 1'b1;
               next_write      = 1'b1;
               next_sel        = conditional ? `SEL_CONDITION : `SEL_COMMAND;
               next_wdata      = op_word;
               next_state      = P_CMD;
            end
         end
         P_CMD: begin
            if (bus.ack) begin
               next_write = 1'b0;
               next_sel   = `SEL_RESPONSE;
               next_wdata = 16'h0000;
               next_state = P_RESP;
            end
         end
         P_RESP: begin
            if (bus.ack) begin
               next_req = 1'b0;
               // Both categories take the same exception path
               if (resp_kind != FRAME_NONE) begin // RULE_13
                  next_frame_kind = resp_kind;
                  next_exc_vector = bus.rdata[7:0]; // RULE_04
                  next_frame_pc   = cur_opcode; // RULE_05 RULE_07 RULE_10
                  next_frame_scan = cur_scan; // RULE_07 RULE_10
                  next_frame_ea   = cur_ea; // RULE_07
                  case (resp_kind)
                     FRAME_PRE:  next_frame_words = `FRAME_WORDS_PRE; // RULE_05
                     FRAME_MID:  next_frame_words = `FRAME_WORDS_MID; // RULE_07
                     FRAME_POST: next_frame_words = `FRAME_WORDS_POST; // RULE_10
                     default:    next_frame_words = 4'h0;
                  endcase
                  next_req   = 1'b1;
                  next_write = 1'b1;
                  next_sel   = `SEL_CONTROL;
                  next_wdata = `CTRL_EXC_ACK; // RULE_03
                  next_state = P_ACK;
               end else if (!bus.rdata[`PRIM_CA_BIT]) begin
                  // Coprocessor may keep working concurrently after this
                  next_released = 1'b1; // RULE_17
                  next_busy     = 1'b0;
                  next_state    = P_IDLE;
               end else begin
                  next_req = 1'b1;
               end
            end
         end
         P_ACK: begin
            // Exception processing starts only once the mask write completed
            if (bus.ack) begin // RULE_03
               next_req       = 1'b0;
               next_write     = 1'b0;
               next_exc_frame = 1'b1;
               next_state     = P_FRAME;
            end
         end
         P_FRAME: begin
            if (return_from_exception_op) begin
               next_exc_frame = 1'b0;
               if (frame_modified) begin
                  // Handler rewrote the frame, the instruction is abandoned
                  next_busy  = 1'b0;
                  next_state = P_IDLE;
               end else begin
                  case (frame_kind)
                     FRAME_PRE: begin
                        next_restart = 1'b1; // RULE_06
                        next_req     = 1'b1;
                        next_write   = 1'b1;
                        next_sel     = is_cond ? `SEL_CONDITION : `SEL_COMMAND;
                        next_wdata   = cmd_word;
                        next_state   = P_CMD;
                     end
                     FRAME_MID: begin
                        next_req   = 1'b1; // RULE_09
                        next_write = 1'b0;
                        next_sel   = `SEL_RESPONSE;
                        next_state = P_RESP;
                     end
                     default: begin
                        next_fetch_valid = 1'b1;
                        next_fetch_addr  = frame_scan; // RULE_11
                        next_busy        = 1'b0;
                        next_state       = P_IDLE;
                     end
                  endcase
               end
            end
         end
         default: begin
            next_state = P_IDLE;
            next_req   = 1'b0;
            next_busy  = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state       <= P_IDLE;
         bus.req     <= 1'b0;
         bus.write   <= 1'b0;
         bus.sel     <= `SEL_RESPONSE;
         bus.wdata   <= 16'h0000;
         cmd_word    <= 16'h0000;
         is_cond     <= 1'b0;
         cur_opcode  <= 32'h0000_0000;
         cur_scan    <= 32'h0000_0000;
         cur_ea      <= 32'h0000_0000;
         busy        <= 1'b0;
         exc_frame   <= 1'b0;
         frame_kind  <= FRAME_NONE;
         frame_words <= 4'h0;
         exc_vector  <= 8'h00;
         frame_pc    <= 32'h0000_0000;
         frame_scan  <= 32'h0000_0000;
         frame_ea    <= 32'h0000_0000;
         released    <= 1'b0;
         restart     <= 1'b0;
         fetch_valid <= 1'b0;
         fetch_addr  <= 32'h0000_0000;
      end else begin
         state       <= next_state;
         bus.req     <= next_req;
         bus.write   <= next_write;
         bus.sel     <= next_sel;
         bus.wdata   <= next_wdata;
         cmd_word    <= next_cmd_word;
         is_cond     <= next_is_cond;
         cur_opcode  <= next_cur_opcode;
         cur_scan    <= next_cur_scan;
         cur_ea      <= next_cur_ea;
         busy        <= next_busy;
         exc_frame   <= next_exc_frame;
         frame_kind  <= next_frame_kind;
         frame_words <= next_frame_words;
         exc_vector  <= next_exc_vector;
         frame_pc    <= next_frame_pc;
         frame_scan  <= next_frame_scan;
         frame_ea    <= next_frame_ea;
         released    <= next_released;
         restart     <= next_restart;
         fetch_valid <= next_fetch_valid;
         fetch_addr  <= next_fetch_addr;
      end
   end
endmodule : coproc_exc_proc

// file: rtl/coproc_exc_regs.svh
// Offsets, primitive codes, masks and frame sizes for the coprocessor exception dialog
`ifndef COPROC_EXC_REGS_SVH
`define COPROC_EXC_REGS_SVH

// Interface register selectors
`define SEL_RESPONSE     3'h0
`define SEL_CONTROL      3'h1
`define SEL_COMMAND      3'h2
`define SEL_CONDITION    3'h3

// Primitive word fields
`define PRIM_CA_BIT      15
`define PRIM_PC_BIT      14
`define PRIM_CODE_MASK   8'hBF
`define PRIM_CODE_PRE    8'h1C
`define PRIM_CODE_MID    8'h1D
`define PRIM_CODE_POST   8'h1E
`define PRIM_CODE_REL    8'h02

// Control register mask that acknowledges an exception request
`define CTRL_EXC_ACK     16'h0002

// Vector used for unrecognized command or condition words
`define VEC_FLINE        8'h0B

// Stack frame sizes in words
`define FRAME_WORDS_PRE  4'h4
`define FRAME_WORDS_MID  4'hA
`define FRAME_WORDS_POST 4'h6

`endif

// file: rtl/coproc_exc_pkg.sv
// Types shared by both ends of the coprocessor exception dialog
package coproc_exc_pkg;
   typedef enum logic [1:0] {
      FRAME_NONE,
      FRAME_PRE,
      FRAME_MID,
      FRAME_POST
   } frame_kind_e;

   typedef enum logic [2:0] {
      RK_BUSY,
      RK_RELEASE,
      RK_DONE,
      RK_PRE,
      RK_MID,
      RK_POST
   } resp_kind_e;
endpackage : coproc_exc_pkg

// file: rtl/coproc_interface_register_if.sv
// Interface register access path between the processor and the coprocessor
`timescale 1ns/1ps
interface coproc_interface_register_if;
   logic        req;
   logic        write;
   logic [2:0]  sel;
   logic [15:0] wdata;
   logic        ack;
   logic [15:0] rdata;

   modport proc (output req, output write, output sel, output wdata, input ack, input rdata);
   modport cop  (input req, input write, input sel, input wdata, output ack, output rdata);
endinterface : coproc_interface_register_if

// file: rtl/coproc_exc_cop.sv
// Coprocessor end: answers register accesses and chooses take-exception primitives
`timescale 1ns/1ps
`include "coproc_exc_regs.svh"
module coproc_exc_cop
   import coproc_exc_pkg::*;
#(
   parameter logic [7:0] PRE_CODE = `PRIM_CODE_PRE
) (
   input  wire logic                        clk,
   input  wire logic                        reset_n,
   coproc_interface_register_if.cop         bus,
   input  coproc_exc_pkg::resp_kind_e       resp_kind,
   input  wire logic [7:0]                  resp_vector,
   input  wire logic                        record_addr,
   input  wire logic                        cmd_known,
   input  wire logic                        resources_modified,
   input  wire logic                        conc_exc,
   input  wire logic [7:0]                  conc_vector,
   output logic                             cmd_strobe,
   output logic [15:0]                      cmd_word,
   output logic                             exc_acked,
   output logic                             pending
);
   import coproc_exc_pkg::*;

   function automatic logic [15:0] prim(input logic ca, input logic pcf, input logic [7:0] code,
                                        input logic [7:0] low);
      prim = {ca, pcf, code[5:0], low};
   endfunction : prim

   logic         next_ack;
   logic [15:0]  next_rdata;
   logic         next_cmd_strobe;
   logic [15:0]  next_cmd_word;
   logic         next_exc_acked;
   logic         next_pending;
   logic [7:0]   pend_vec;
   logic [7:0]   next_pend_vec;
   logic         concurrent;
   logic         next_concurrent;
   logic         cmd_seen;
   logic         next_cmd_seen;
   logic         take;

   assign take = bus.req && !bus.ack;

   //==================================================================
   // Register access and primitive selection
   always_comb begin
      next_ack        = take;
      next_rdata      = bus.rdata;
      next_cmd_strobe = 1'b0;
      next_cmd_word   = cmd_word;
      next_exc_acked  = 1'b0;
      next_pending    = pending;
      next_pend_vec   = pend_vec;
      next_concurrent = concurrent;
      next_cmd_seen   = cmd_seen;
      if (take && bus.write && bus.sel == `SEL_CONTROL && bus.wdata == `CTRL_EXC_ACK) begin
         next_exc_acked = 1'b1;
      end
      if (take && bus.write && (bus.sel == `SEL_COMMAND || bus.sel == `SEL_CONDITION)) begin
         next_cmd_strobe = 1'b1;
         next_cmd_word   = bus.wdata;
         next_cmd_seen   = 1'b1;
      end
      if (take && !bus.write && bus.sel == `SEL_RESPONSE) begin
         next_cmd_seen = 1'b0;
         if (pending && cmd_seen) begin
            // Deferred concurrent exception reported at next instruction start
            next_rdata   = prim(1'b0, 1'b0, PRE_CODE, pend_vec); // RULE_16 RULE_20
            next_pending = 1'b0;
         end else if (cmd_seen && !cmd_known) begin
            next_rdata = prim(1'b0, 1'b0, PRE_CODE, `VEC_FLINE); // RULE_15
         end else begin
            case (resp_kind)
               RK_PRE: begin
                  // A restart after visible changes would see stale state
                  if (resources_modified)
                     next_rdata = prim(1'b0, record_addr, `PRIM_CODE_MID, resp_vector); // RULE_14
                  else
                     next_rdata = prim(1'b0, record_addr, PRE_CODE, resp_vector); // RULE_15
               end
               RK_MID:  next_rdata = prim(1'b0, record_addr, `PRIM_CODE_MID, resp_vector); // RULE_01 RULE_19
               RK_POST: next_rdata = prim(1'b0, record_addr, `PRIM_CODE_POST, resp_vector); // RULE_02 RULE_12
               RK_RELEASE: begin
                  next_rdata      = prim(1'b0, record_addr, `PRIM_CODE_REL, 8'h00); // RULE_17 RULE_18
                  next_concurrent = 1'b1;
               end
               RK_DONE:  next_rdata = prim(1'b0, 1'b0, `PRIM_CODE_REL, 8'h00);
               default:  next_rdata = prim(1'b1, 1'b0, `PRIM_CODE_REL, 8'h00);
            endcase
         end
      end else if (take && !bus.write) begin
         next_rdata = 16'h0000;
      end
      if (next_cmd_strobe) begin
         next_concurrent = 1'b0;
      end
      // A new concurrent exception wins over the clear by a report
      if (conc_exc && concurrent) begin // RULE_16
         next_pending  = 1'b1;
         next_pend_vec = conc_vector;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         bus.ack    <= 1'b0;
         bus.rdata  <= 16'h0000;
         cmd_strobe <= 1'b0;
         cmd_word   <= 16'h0000;
         exc_acked  <= 1'b0;
         pending    <= 1'b0;
         pend_vec   <= 8'h00;
         concurrent <= 1'b0;
         cmd_seen   <= 1'b0;
      end else begin
         bus.ack    <= next_ack;
         bus.rdata  <= next_rdata;
         cmd_strobe <= next_cmd_strobe;
         cmd_word   <= next_cmd_word;
         exc_acked  <= next_exc_acked;
         pending    <= next_pending;
         pend_vec   <= next_pend_vec;
         concurrent <= next_concurrent;
         cmd_seen   <= next_cmd_seen;
      end
   end
endmodule : coproc_exc_cop

// file: dv/coproc_exc_chk.sv
// Bus-level assertions on the interface register path between the two ends
`timescale 1ns/1ps
`include "coproc_exc_regs.svh"
module coproc_exc_chk #(
   parameter logic [7:0] PRE_CODE = `PRIM_CODE_PRE
) (
   input wire logic        clk,
   input wire logic        reset_n,
   input wire logic        req,
   input wire logic        write,
   input wire logic [2:0]  sel,
   input wire logic [15:0] wdata,
   input wire logic        ack,
   input wire logic [15:0] rdata
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   //==================================================================
   // Response decode, flag bit masked off the code byte
   logic [7:0] code;
   logic       rd_done;
   logic       is_exc;
   assign code    = rdata[15:8] & `PRIM_CODE_MASK;
   assign rd_done = ack && !write && (sel == `SEL_RESPONSE);
   assign is_exc  = (code == PRE_CODE) || (code == `PRIM_CODE_MID) || (code == `PRIM_CODE_POST);
   //==================================================================
   // Handshake
   property p_take_ack;
      req && !ack |=> ack;
   endproperty
   a_take_ack: assert property (p_take_ack) else $error("access not answered next cycle");
   property p_hold;
      req && !ack |=> req && $stable(write) && $stable(sel) && $stable(wdata);
   endproperty
   a_hold: assert property (p_hold) else $error("request changed before answer");
   //==================================================================
   // Exception acknowledge sequence
   property p_ack_mask;
      req && write && (sel == `SEL_CONTROL) |-> wdata == `CTRL_EXC_ACK;
   endproperty
   a_ack_mask: assert property (p_ack_mask) else $error("wrong control mask");
   property p_exc_ack;
      rd_done && is_exc |=> req && write && (sel == `SEL_CONTROL);
   endproperty
   a_exc_ack: assert property (p_exc_ack) else $error("exception not acknowledged first");
   property p_ctrl_after;
      req && !ack && write && (sel == `SEL_CONTROL) |-> $past(rd_done) && $past(is_exc);
   endproperty
   a_ctrl_after: assert property (p_ctrl_after) else $error("control write without exception");
   //==================================================================
   // Dialog order
   property p_cmd_resp;
      ack && write && (sel == `SEL_COMMAND || sel == `SEL_CONDITION) |=> req && !write && (sel == `SEL_RESPONSE);
   endproperty
   a_cmd_resp: assert property (p_cmd_resp) else $error("no response read after command");
   property p_release;
      rd_done && !rdata[15] && !is_exc |=> !req;
   endproperty
   a_release: assert property (p_release) else $error("bus kept after release");
   property p_reread;
      rd_done && rdata[15] && !is_exc |=> req && !write && (sel == `SEL_RESPONSE);
   endproperty
   a_reread: assert property (p_reread) else $error("come-again not honoured");
endmodule : coproc_exc_chk

// file: dv/tb_top.sv
// Self-checking bench for both ends of the coprocessor exception dialog
`timescale 1ns/1ps
`include "coproc_exc_regs.svh"
`define CHK(g,e,m) begin compares++; if ((g)!==(e)) begin n_errors++; $display("CHECK FAILED %0t %s",$time,m); end end
module tb_top;
   import coproc_exc_pkg::*;
   typedef struct {
      resp_kind_e  kind;
      logic [7:0]  vec;
      logic        cond;
      logic        eav;
      frame_kind_e fk;
      logic [3:0]  words;
      logic [7:0]  code;
   } row_s;
   logic        clk, reset_n, start, conditional, ea_valid, return_from_exception_op, frame_modified;
   logic [15:0] op_word, last_prim, cmd_word;
   logic [31:0] opcode_addr, scan_ptr, ea, fetch_addr, frame_pc, frame_scan, frame_ea, fet_a;
   logic        busy, exc_frame, released, restart, fetch_valid;
   logic [3:0]  frame_words;
   logic [7:0]  exc_vector, resp_vector, conc_vector;
   frame_kind_e frame_kind;
   resp_kind_e  resp_kind;
   logic        record_addr, cmd_known, resources_modified, conc_exc, cmd_strobe, exc_acked, pending;
   int          n_errors, compares, n_ack, n_rst, n_rel, n_fet, n_cmd, a0;
   row_s        rows [6] = '{
      '{RK_PRE, 8'h30, 1'b0, 1'b0, FRAME_PRE, 4'h4, `PRIM_CODE_PRE},
      '{RK_PRE, 8'h31, 1'b1, 1'b1, FRAME_PRE, 4'h4, `PRIM_CODE_PRE},
      '{RK_MID, 8'h32, 1'b0, 1'b1, FRAME_MID, 4'hA, 8'h1D},
      '{RK_MID, 8'h33, 1'b1, 1'b0, FRAME_MID, 4'hA, 8'h1D},
      '{RK_POST, 8'h34, 1'b0, 1'b0, FRAME_POST, 4'h6, 8'h1E},
      '{RK_POST, 8'h35, 1'b1, 1'b1, FRAME_POST, 4'h6, 8'h1E}};
   coproc_interface_register_if cif ();
   coproc_exc_proc coproc_exc_proc_inst (.clk, .reset_n, .bus(cif), .start, .conditional, .op_word,
      .opcode_addr, .scan_ptr, .ea_valid, .ea, .return_from_exception_op, .frame_modified, .busy, .exc_frame, .frame_kind,
      .frame_words, .exc_vector, .frame_pc, .frame_scan, .frame_ea, .released, .restart, .fetch_valid,
      .fetch_addr);
   coproc_exc_cop coproc_exc_cop_inst (.clk, .reset_n, .bus(cif), .resp_kind, .resp_vector, .record_addr,
      .cmd_known, .resources_modified, .conc_exc, .conc_vector, .cmd_strobe, .cmd_word, .exc_acked, .pending);
   coproc_exc_chk #(.PRE_CODE(`PRIM_CODE_PRE)) coproc_exc_chk_inst (.clk, .reset_n, .req(cif.req),
      .write(cif.write), .sel(cif.sel), .wdata(cif.wdata), .ack(cif.ack), .rdata(cif.rdata));
   //==================================================================
   // Pulse counters, so that one-cycle outputs are never missed
   always @(posedge clk) begin
      if (exc_acked === 1'b1) n_ack++;
      if (restart === 1'b1) n_rst++;
      if (released === 1'b1) n_rel++;
      if (cmd_strobe === 1'b1) n_cmd++;
      if (fetch_valid === 1'b1) begin
         n_fet++;
         fet_a = fetch_addr;
      end
      if (cif.ack === 1'b1 && cif.write === 1'b0 && cif.sel === `SEL_RESPONSE) last_prim = cif.rdata;
   end
   //==================================================================
   // Tasks
   task automatic report_and_stop();
      $display("compares=%0d n_errors=%0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : report_and_stop
   task automatic issue(input resp_kind_e k, input logic [7:0] v, input logic c, input logic e);
      resp_kind = k;
      resp_vector = v;
      conditional = c;
      ea_valid = e;
      opcode_addr = opcode_addr + 32'h0000_0010;
      scan_ptr = opcode_addr + 32'h0000_0004;
      ea = ~opcode_addr;
      op_word = op_word + 16'h0001;
      a0 = n_ack;
      start = 1'b1;
      @(negedge clk);
      start = 1'b0;
   endtask : issue
   task automatic wait_idle();
      for (int k = 0; k < 200 && busy !== 1'b0; k++) @(negedge clk);
      `CHK(busy, 1'b0, "not idle")
      @(negedge clk);
   endtask : wait_idle
   task automatic check_frame(input frame_kind_e fk, input logic [3:0] w, input logic [7:0] v, input logic [7:0] c);
      for (int k = 0; k < 100 && exc_frame !== 1'b1; k++) @(negedge clk);
      @(negedge clk);
      `CHK(exc_frame, 1'b1, "no frame")
      `CHK(n_ack - a0, 1, "ack mask")
      `CHK(frame_kind, fk, "frame kind")
      `CHK(frame_words, w, "frame words")
      `CHK(exc_vector, v, "vector")
      `CHK(frame_pc, opcode_addr, "frame pc")
      `CHK(last_prim & 16'hBFFF, {c, v}, "primitive word")
      `CHK(cmd_word, op_word, "command word")
      if (fk != FRAME_PRE) `CHK(frame_scan, scan_ptr, "frame scan")
      if (fk == FRAME_MID && ea_valid) `CHK(frame_ea, ea, "frame ea")
   endtask : check_frame
   task automatic finish(input frame_kind_e fk, input logic m);
      int r0, l0, f0, c0;
      r0 = n_rst;
      l0 = n_rel;
      f0 = n_fet;
      c0 = n_cmd;
      resp_kind = RK_RELEASE;
      cmd_known = 1'b1;
      resources_modified = 1'b0;
      return_from_exception_op = 1'b1;
      frame_modified = m;
      @(negedge clk);
      return_from_exception_op = 1'b0;
      @(negedge clk);
      wait_idle();
      `CHK(exc_frame, 1'b0, "frame kept")
      `CHK(n_rst - r0, (!m && fk == FRAME_PRE) ? 1 : 0, "restart")
      `CHK(n_cmd - c0, (!m && fk == FRAME_PRE) ? 1 : 0, "reissue")
      `CHK(n_rel - l0, (!m && fk != FRAME_POST) ? 1 : 0, "resume")
      `CHK(n_fet - f0, (!m && fk == FRAME_POST) ? 1 : 0, "fetch")
      if (!m && fk == FRAME_POST) `CHK(fet_a, scan_ptr, "fetch address")
   endtask : finish
   //==================================================================
   // Clock, watchdog and main sequence
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial begin
      #(5.0 * 20000);
      n_errors++;
      report_and_stop();
   end
   initial begin
      reset_n = 1'b0;
      start = 1'b0;
      conditional = 1'b0;
      ea_valid = 1'b0;
      return_from_exception_op = 1'b0;
      frame_modified = 1'b0;
      op_word = 16'hF200;
      opcode_addr = 32'h0000_2000;
      scan_ptr = 32'h0000_2004;
      ea = 32'h0000_0000;
      resp_kind = RK_RELEASE;
      resp_vector = 8'h00;
      record_addr = 1'b0;
      cmd_known = 1'b1;
      resources_modified = 1'b0;
      conc_exc = 1'b0;
      conc_vector = 8'h00;
      repeat (10) @(negedge clk);
      reset_n = 1'b1;
      @(negedge clk);
      `CHK({busy, exc_frame, pending, cif.req}, 4'h0, "reset state")
      foreach (rows[i]) begin
         issue(rows[i].kind, rows[i].vec, rows[i].cond, rows[i].eav);
         check_frame(rows[i].fk, rows[i].words, rows[i].vec, rows[i].code);
         finish(rows[i].fk, 1'b0);
      end
      // Unrecognised condition word
      cmd_known = 1'b0;
      issue(RK_MID, 8'h21, 1'b1, 1'b0);
      check_frame(FRAME_PRE, 4'h4, 8'h0B, `PRIM_CODE_PRE);
      finish(FRAME_PRE, 1'b0);
      // Visible state already changed, frame edited by the handler
      resources_modified = 1'b1;
      issue(RK_PRE, 8'h22, 1'b0, 1'b1);
      check_frame(FRAME_MID, 4'hA, 8'h22, 8'h1D);
      finish(FRAME_MID, 1'b1);
      // Come-again keeps the processor polling
      issue(RK_BUSY, 8'h00, 1'b0, 1'b0);
      repeat (20) @(negedge clk);
      `CHK(busy, 1'b1, "held by come-again")
      resp_kind = RK_DONE;
      wait_idle();
      // Early release, then an exception during the concurrent run
      record_addr = 1'b1;
      issue(RK_RELEASE, 8'h00, 1'b0, 1'b0);
      wait_idle();
      record_addr = 1'b0;
      `CHK(last_prim[15:14], 2'b01, "early release flags")
      conc_vector = 8'h44;
      conc_exc = 1'b1;
      @(negedge clk);
      conc_exc = 1'b0;
      @(negedge clk);
      `CHK(pending, 1'b1, "deferred exception")
      issue(RK_POST, 8'h55, 1'b1, 1'b0);
      check_frame(FRAME_PRE, 4'h4, 8'h44, `PRIM_CODE_PRE);
      finish(FRAME_PRE, 1'b0);
      report_and_stop();
   end
endmodule : tb_top
